// ===== core/magnet_sup_pkg.sv
// constants and types for the magnet ramp and quench supervisor
package magnet_sup_pkg;
    localparam int CUR_W = 24;
    localparam int TIME_W = 16;
    localparam int MCLK_HZ = 25000000;
    // cooled and heated times default to 20 s
    localparam int SWITCH_COOL_S = 20;
    localparam int SWITCH_HEAT_S = 20;
    localparam int SEC_CYCLES = MCLK_HZ;
    // persistent threshold about 0.1 percent of max current
    localparam int PERSIST_DIV = 1000;
    localparam logic [3:0] MODE_RESET = 4'h0;

    typedef enum logic [3:0] {
        MODE_PAUSED = 4'h0,
        MODE_RAMPING = 4'h1,
        MODE_HOLDING = 4'h2,
        MODE_ZERO = 4'h3,
        MODE_HEATING = 4'h4,
        MODE_COOLING = 4'h5,
        MODE_PS_DOWN = 4'h6,
        MODE_PS_MATCH = 4'h7,
        MODE_TO_ZERO = 4'h8,
        MODE_QUENCH = 4'h9
    } mode_t;
endpackage

// ===== core/magnet_ramp_quench_supervisor.sv
// mode sequencer and quench protection for a magnet current programmer
//
// Overview of operation
// - switch off enters cooling, ramps refused
// - persistent lamp only above tenth percent
// - switch on enters heating, ramps refused
// - heating done clears lamp, goes paused
// - ramp key from paused starts ramping
// - target reached switches to holding
// - new target while holding restarts ramp
// - ramp key toggles ramping and paused
// - after cooling with persistent lamp on, supply ramps down fast
// - switch key in persistent matches magnet
// - zero key ramps down, then zero mode
// - reference versus measured mismatch means quench
// - temperature limit also trips when enabled
// - quench zeros volts, contact, lamp, locks
// - locked reset key needs correct password
// - clearing quench pauses at present current
// - external contact always trips, fail safe
// - external asserted blocks key clear
// - internal detection optional, contact always works
// - detection off limits error, follows magnet, with heater on in paused, holding or zero mode; ramp steps override it
// - external input forces zero volts always
// - unexpected switch normal: quench when internal detection enabled
`timescale 1ns/10ps
`default_nettype none
module magnet_ramp_quench_supervisor
    import magnet_sup_pkg::*;
#(
    parameter int CW = CUR_W,
    parameter int COOL_CYCLES = SWITCH_COOL_S * SEC_CYCLES,
    parameter int HEAT_CYCLES = SWITCH_HEAT_S * SEC_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // operator keys, one-cycle pulses
    input wire logic rampPauseKey,
    input wire logic ramp_down_key,
    input wire logic switch_control_key,
    input wire logic shiftKey,
    input wire logic resetQuenchKey,
    input wire logic remoteClear,
    input wire logic resetKeyLocked,
    input wire logic passwordOk,
    // configuration
    input wire logic signed [CW-1:0] targetCur,
    input wire logic targetLoad,
    input wire logic [CW-1:0] rampStep,
    input wire logic [CW-1:0] fastStep,
    input wire logic [CW-1:0] maxOutCur,
    input wire logic [CW-1:0] quenchMargin,
    input wire logic [CW-1:0] errLimit,
    input wire logic internalDetectEn,
    input wire logic tempDetectEn,
    input wire logic tempOverLimit,
    // plant measurement
    input wire logic signed [CW-1:0] measCur,
    input wire logic extQuenchIn,
    input wire logic switchNormal,
    // outputs
    output logic signed [CW-1:0] refCur,
    output logic zeroVolts,
    output logic quenchContact,
    output logic quenchLed,
    output logic persistLed,
    output logic heaterOn,
    output logic [3:0] modeOut
);
    mode_t mode_ff, nxt_mode;
    logic signed [CW-1:0] ref_ff, nxt_ref, magCur_ff, nxt_magCur, goal;
    logic [31:0] timer_ff, nxt_timer;
    logic heater_ff, nxt_heater, persist_ff, nxt_persist, quench_ff, nxt_quench;
    logic signed [CW-1:0] diff, err, stepS, fastS;
    logic [CW-1:0] absErr, absMeas;
    wire logic mismatch, tripInt, tripAny, keyClear, clearOk, atGoal, timerDone;
    wire logic switchSteady, switchSpont, idleMode;
    wire logic signed [CW-1:0] towardGoal, limited;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        err = ref_ff - measCur;
        absErr = err[CW-1] ? CW'(-err) : CW'(err);
        absMeas = measCur[CW-1] ? CW'(-measCur) : CW'(measCur);
        stepS = (mode_ff == MODE_PS_DOWN || mode_ff == MODE_PS_MATCH) ?
            $signed(fastStep) : $signed(rampStep);
        fastS = stepS;
        diff = goal - ref_ff;
    end

    assign mismatch = absErr > quenchMargin;
    // unexpected normal switch while persistent trips alongside a mismatch
    assign switchSpont = switchNormal && !heater_ff && persist_ff;
    assign tripInt = internalDetectEn && (mismatch || switchSpont);
    assign tripAny = tripInt || (tempDetectEn && tempOverLimit) || extQuenchIn;
    assign keyClear = resetQuenchKey && (!resetKeyLocked || passwordOk);
    assign clearOk = (keyClear && !extQuenchIn) || remoteClear;
    // count ends at one, so a load of N lasts N cycles
    assign timerDone = timer_ff == 32'h0000_0001;
    assign switchSteady = !(mode_ff == MODE_HEATING || mode_ff == MODE_COOLING);
    assign idleMode = mode_ff == MODE_PAUSED || mode_ff == MODE_HOLDING;
    assign atGoal = diff == '0;
    // one step toward goal, never overshooting
    assign towardGoal = diff[CW-1] ?
        ((-diff > fastS) ? ref_ff - fastS : goal) :
        ((diff > fastS) ? ref_ff + fastS : goal);
    // detection off: keep reference within errLimit of measured
    assign limited = (absErr > errLimit) ?
        (err[CW-1] ? measCur - $signed(errLimit) : measCur + $signed(errLimit)) :
        ref_ff;

    always_comb begin
        unique case (mode_ff)
            MODE_PS_DOWN, MODE_TO_ZERO: goal = '0;
            MODE_PS_MATCH: goal = magCur_ff;
            default: goal = targetCur;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_mode = mode_ff;
        nxt_ref = ref_ff;
        nxt_timer = (timer_ff != 0) ? timer_ff - 32'h0000_0001 : timer_ff;
        nxt_heater = heater_ff;
        nxt_persist = persist_ff;
        nxt_quench = quench_ff;
        nxt_magCur = magCur_ff;
        if (quench_ff) begin
            // all keys ignored until cleared
            // a trip in the clearing cycle wins, quench stays latched
            if (clearOk && !tripAny) begin
                nxt_quench = 1'b0;
                nxt_mode = MODE_PAUSED;
                nxt_ref = measCur;
            end
        end else if (tripAny) begin
            nxt_quench = 1'b1;
            nxt_mode = MODE_QUENCH;
        end else begin
            if (!internalDetectEn && switchSteady && heater_ff) begin
                nxt_ref = limited;
            end
            unique case (mode_ff)
                MODE_PAUSED, MODE_HOLDING, MODE_ZERO: begin
                    if (shiftKey && switch_control_key && idleMode) begin
                        nxt_heater = !heater_ff;
                        if (heater_ff) begin
                            nxt_mode = MODE_COOLING;
                            nxt_timer = 32'(COOL_CYCLES);
                            nxt_magCur = measCur;
                            nxt_persist = absMeas > CW'(maxOutCur / CW'(PERSIST_DIV));
                        end else begin
                            nxt_mode = MODE_HEATING;
                            nxt_timer = 32'(HEAT_CYCLES);
                        end
                    end else if (!shiftKey && switch_control_key && persist_ff) begin
                        nxt_mode = MODE_PS_MATCH;
                    end else if (ramp_down_key) begin
                        nxt_mode = MODE_TO_ZERO;
                    end else if (rampPauseKey && mode_ff == MODE_PAUSED) begin
                        nxt_mode = MODE_RAMPING;
                    end else if (targetLoad && mode_ff == MODE_HOLDING) begin
                        nxt_mode = MODE_RAMPING;
                    end
                end
                MODE_RAMPING: begin
                    if (rampPauseKey) begin
                        nxt_mode = MODE_PAUSED;
                    end else if (atGoal) begin
                        nxt_mode = MODE_HOLDING;
                    end else begin
                        nxt_ref = towardGoal;
                    end
                end
                MODE_TO_ZERO: begin
                    if (atGoal) begin
                        nxt_mode = MODE_ZERO;
                    end else if (rampPauseKey) begin
                        nxt_mode = MODE_PAUSED;
                    end else begin
                        nxt_ref = towardGoal;
                    end
                end
                MODE_COOLING: begin
                    // ramp keys refused here
                    if (timerDone) begin
                        nxt_mode = persist_ff ? MODE_PS_DOWN : MODE_PAUSED;
                    end
                end
                MODE_HEATING: begin
                    if (timerDone) begin
                        nxt_persist = 1'b0;
                        nxt_mode = MODE_PAUSED;
                    end
                end
                MODE_PS_DOWN: begin
                    if (atGoal) begin
                        nxt_mode = MODE_ZERO;
                    end else begin
                        nxt_ref = towardGoal;
                    end
                end
                MODE_PS_MATCH: begin
                    if (atGoal) begin
                        nxt_mode = MODE_HOLDING;
                    end else begin
                        nxt_ref = towardGoal;
                    end
                end
                default: nxt_mode = MODE_PAUSED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mode_ff <= MODE_PAUSED;
            ref_ff <= '0;
            magCur_ff <= '0;
            timer_ff <= '0;
            // heater on after reset: magnet taken as driven, not persistent
            heater_ff <= 1'b1;
            persist_ff <= 1'b0;
            quench_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            ref_ff <= nxt_ref;
            magCur_ff <= nxt_magCur;
            timer_ff <= nxt_timer;
            heater_ff <= nxt_heater;
            persist_ff <= nxt_persist;
            quench_ff <= nxt_quench;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            refCur <= '0;
            zeroVolts <= 1'b0;
            quenchContact <= 1'b0;
            quenchLed <= 1'b0;
            persistLed <= 1'b0;
            heaterOn <= 1'b1;
            modeOut <= MODE_RESET;
        end else begin
            refCur <= nxt_ref;
            zeroVolts <= nxt_quench || extQuenchIn;
            quenchContact <= nxt_quench;
            quenchLed <= nxt_quench;
            persistLed <= nxt_persist;
            heaterOn <= nxt_heater;
            modeOut <= nxt_mode;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    ext_zero_a: assert property (extQuenchIn |=> zeroVolts)
        else $error("external quench did not zero volts");
    quench_latch_a: assert property (quench_ff && !clearOk |=> quench_ff)
        else $error("quench dropped without clear");
    ext_block_a: assert property (quench_ff && extQuenchIn |=> quench_ff)
        else $error("quench cleared while external asserted");
    clear_pause_a: assert property (quench_ff && !nxt_quench |=> mode_ff == MODE_PAUSED)
        else $error("quench clear not paused");
    cool_noramp_a: assert property (mode_ff == MODE_COOLING && !tripAny
        |=> mode_ff inside {MODE_COOLING, MODE_PAUSED, MODE_PS_DOWN})
        else $error("left cooling early");
    heat_end_a: assert property (mode_ff == MODE_HEATING && timerDone && !tripAny
        |=> mode_ff == MODE_PAUSED && !persist_ff)
        else $error("heating end wrong");
    goal_hold_a: assert property (mode_ff == MODE_RAMPING && atGoal && !rampPauseKey
        && !tripAny |=> mode_ff == MODE_HOLDING)
        else $error("no hold at target");
    heat_noramp_a: assert property (mode_ff == MODE_HEATING && !timerDone && !tripAny
        |=> mode_ff == MODE_HEATING)
        else $error("left heating early");
    cool_enter_a: assert property (idleMode && heater_ff && shiftKey && switch_control_key
        && !tripAny |=> mode_ff == MODE_COOLING && !heaterOn)
        else $error("heater off did not enter cooling");
    spont_trip_a: assert property (internalDetectEn && switchSpont |=> quench_ff)
        else $error("spontaneous switch normal did not trip");
    clear_ref_a: assert property (quench_ff && !nxt_quench |=> refCur == $past(measCur))
        else $error("quench clear did not keep present current");
    temp_trip_a: assert property (tempDetectEn && tempOverLimit |=> quench_ff)
        else $error("temperature did not trip");
    mismatch_trip_a: assert property (internalDetectEn && mismatch |=> quench_ff)
        else $error("mismatch did not trip");
    contact_led_a: assert property (!internalDetectEn && extQuenchIn
        |=> quenchContact && quenchLed)
        else $error("contact inactive with detection off");

    c_quench_c: cover property (quench_ff ##1 !quench_ff);
    c_ramp_hold_c: cover property (mode_ff == MODE_RAMPING ##1 mode_ff == MODE_HOLDING);
    c_cool_c: cover property (mode_ff == MODE_COOLING ##1 mode_ff == MODE_PS_DOWN);
    c_zero_c: cover property (mode_ff == MODE_TO_ZERO ##1 mode_ff == MODE_ZERO);
    c_spont_c: cover property (switchSpont ##1 quench_ff);
endmodule
`default_nettype wire

// ===== tb/magnet_plant_model.sv
// supply and coil model: the measured current follows the reference
`timescale 1ns/10ps
`default_nettype none
module magnet_plant_model
    import magnet_sup_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // supply command and injected error
    input wire logic signed [CUR_W-1:0] refCur,
    input wire logic signed [CUR_W-1:0] offsetCur,
    // measurement
    output logic signed [CUR_W-1:0] measCur
);
    logic signed [CUR_W-1:0] measCur_ff;
    // one cycle of lag, so ramps show a mismatch of one step only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            measCur_ff <= '0;
        end else begin
            measCur_ff <= refCur + offsetCur;
        end
    end
    assign measCur = measCur_ff;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the magnet ramp and quench supervisor
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import magnet_sup_pkg::*;
;
    logic mclk, resetn, shiftKey, resetKeyLocked, passwordOk, internalDetectEn;
    logic tempDetectEn, tempOverLimit, extQuenchIn, switchNormal;
    logic zeroVolts, quenchContact, quenchLed, persistLed, heaterOn;
    logic [5:0] keys;
    logic [CUR_W-1:0] rampStep, fastStep, maxOutCur, quenchMargin, errLimit;
    logic signed [CUR_W-1:0] targetCur, measCur, refCur, offsetCur, tgt, held;
    logic [3:0] modeOut;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    magnet_ramp_quench_supervisor #(.COOL_CYCLES(10), .HEAT_CYCLES(10))
        i_magnet_ramp_quench_supervisor (.mclk(mclk), .resetn(resetn),
        .rampPauseKey(keys[0]), .ramp_down_key(keys[1]), .switch_control_key(keys[2]),
        .shiftKey(shiftKey), .resetQuenchKey(keys[3]), .remoteClear(keys[4]),
        .resetKeyLocked(resetKeyLocked), .passwordOk(passwordOk), .targetCur(targetCur),
        .targetLoad(keys[5]), .rampStep(rampStep), .fastStep(fastStep),
        .maxOutCur(maxOutCur), .quenchMargin(quenchMargin), .errLimit(errLimit),
        .internalDetectEn(internalDetectEn), .tempDetectEn(tempDetectEn),
        .tempOverLimit(tempOverLimit), .measCur(measCur), .extQuenchIn(extQuenchIn),
        .switchNormal(switchNormal), .refCur(refCur), .zeroVolts(zeroVolts),
        .quenchContact(quenchContact), .quenchLed(quenchLed), .persistLed(persistLed),
        .heaterOn(heaterOn), .modeOut(modeOut));
    magnet_plant_model i_magnet_plant_model (.mclk(mclk), .resetn(resetn),
        .refCur(refCur), .offsetCur(offsetCur), .measCur(measCur));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle key pulse, outputs settled when this returns
    task automatic press(input logic [5:0] k, input logic sh, input logic pw);
        @(negedge mclk);
        keys = k;
        shiftKey = sh;
        passwordOk = pw;
        @(negedge mclk);
        keys = 6'h00;
        shiftKey = 1'b0;
        passwordOk = 1'b0;
    endtask
    task automatic wait_mode(input logic [3:0] m);
        for (int i = 0; i < 3000 && modeOut !== m; i++) @(negedge mclk);
        chk(modeOut, m);
    endtask
    function automatic logic exp_persist(input logic signed [CUR_W-1:0] c);
        logic [CUR_W-1:0] a;
        a = c[CUR_W-1] ? -c : c;
        return a > maxOutCur / PERSIST_DIV;
    endfunction
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {keys, shiftKey, passwordOk, resetKeyLocked, tempDetectEn} = '0;
        {tempOverLimit, extQuenchIn, switchNormal, targetCur, offsetCur} = '0;
        resetn = 1'b0;
        internalDetectEn = 1'b1;
        rampStep = 24'h000010;
        fastStep = 24'h000040;
        maxOutCur = 24'h010000;
        quenchMargin = 24'h000100;
        errLimit = 24'h001000;
        void'($urandom(93));
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        chk(refCur, 32'h0);
        chk(modeOut, MODE_RESET);
        chk({heaterOn, zeroVolts, quenchContact, quenchLed, persistLed}, 32'h10);
        tgt = CUR_W'(16 * (5 + $urandom % 20));
        targetCur = tgt;
        press(6'h01, 1'b0, 1'b0);
        chk(modeOut, MODE_RAMPING);
        wait_mode(MODE_HOLDING);
        chk(refCur, tgt);
        tgt = tgt + CUR_W'(16 * (10 + $urandom % 10));
        targetCur = tgt;
        press(6'h20, 1'b0, 1'b0);
        chk(modeOut, MODE_RAMPING);
        press(6'h01, 1'b0, 1'b0);
        chk(modeOut, MODE_PAUSED);
        held = refCur;
        repeat (5) @(negedge mclk);
        chk(refCur, held);
        press(6'h01, 1'b0, 1'b0);
        chk(modeOut, MODE_RAMPING);
        wait_mode(MODE_HOLDING);
        $display("test ramp done");
        press(6'h04, 1'b1, 1'b0);
        chk({modeOut, heaterOn}, {MODE_COOLING, 1'b0});
        press(6'h01, 1'b0, 1'b0);
        chk(modeOut, MODE_COOLING);
        wait_mode(MODE_PS_DOWN);
        chk(persistLed, exp_persist(tgt));
        wait_mode(MODE_ZERO);
        chk(refCur, 32'h0);
        switchNormal = 1'b1;
        wait_mode(MODE_QUENCH);
        switchNormal = 1'b0;
        press(6'h08, 1'b0, 1'b0);
        chk(modeOut, MODE_PAUSED);
        press(6'h04, 1'b0, 1'b0);
        chk(modeOut, MODE_PS_MATCH);
        wait_mode(MODE_HOLDING);
        chk(refCur, tgt);
        press(6'h04, 1'b1, 1'b0);
        chk({modeOut, heaterOn}, {MODE_HEATING, 1'b1});
        press(6'h01, 1'b0, 1'b0);
        chk(modeOut, MODE_HEATING);
        wait_mode(MODE_PAUSED);
        chk(persistLed, 1'b0);
        press(6'h02, 1'b0, 1'b0);
        chk(modeOut, MODE_TO_ZERO);
        wait_mode(MODE_ZERO);
        chk(refCur, 32'h0);
        $display("test persistent done");
        offsetCur = CUR_W'(257 + $urandom % 64);
        wait_mode(MODE_QUENCH);
        chk({quenchLed, quenchContact, zeroVolts}, 32'h7);
        press(6'h01, 1'b0, 1'b0);
        chk(modeOut, MODE_QUENCH);
        offsetCur = 24'h000080;
        repeat (2) @(negedge mclk);
        held = measCur;
        press(6'h08, 1'b0, 1'b0);
        chk(modeOut, MODE_PAUSED);
        chk(refCur, held);
        internalDetectEn = 1'b0;
        offsetCur = 24'h000200;
        repeat (6) @(negedge mclk);
        chk(modeOut, MODE_PAUSED);
        extQuenchIn = 1'b1;
        wait_mode(MODE_QUENCH);
        chk({zeroVolts, quenchContact}, 32'h3);
        press(6'h08, 1'b0, 1'b0);
        chk(modeOut, MODE_QUENCH);
        {extQuenchIn, offsetCur} = '0;
        internalDetectEn = 1'b1;
        repeat (2) @(negedge mclk);
        press(6'h08, 1'b0, 1'b0);
        chk(modeOut, MODE_PAUSED);
        {tempDetectEn, tempOverLimit, resetKeyLocked} = 3'b111;
        wait_mode(MODE_QUENCH);
        tempOverLimit = 1'b0;
        press(6'h08, 1'b0, 1'b0);
        chk(modeOut, MODE_QUENCH);
        press(6'h08, 1'b0, 1'b1);
        chk(modeOut, MODE_PAUSED);
        tempOverLimit = 1'b1;
        wait_mode(MODE_QUENCH);
        tempOverLimit = 1'b0;
        press(6'h10, 1'b0, 1'b0);
        chk(modeOut, MODE_PAUSED);
        $display("test quench done");
        complete_run();
    end
endmodule
`default_nettype wire
